// ### scp_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH
`define SCP_OFF_DIV 12'h000
`define SCP_OFF_PLL 12'h004
`define SCP_DIV_CE_BIT 7
`define SCP_DIV_SEL_LSB 0
`define SCP_PLL_PRE_LSB 2
`define SCP_PLL_EN_BIT 1
`define SCP_PLL_LOCK_BIT 0
`define SCP_DIV_RST_PLAIN 4'h0
`define SCP_DIV_RST_FUSED 4'h3
`define SCP_DIV_SEL_MAX 4'h8
`define SCP_CE_WINDOW 3'h4
`define SCP_LOCK_TIME_MS 100
`define SCP_CLK_HZ 25000000
`define SCP_LOCK_CYCLES ((`SCP_LOCK_TIME_MS * `SCP_CLK_HZ) / 1000)
`define SCP_PRE_DIV4 3'h3
`define SCP_PRE_DIV8_LG 3'h5
`define SCP_PRE_DIV8_SM 3'h6
`endif

// ### scp_pkg.sv
// types shared by the clock prescaler and pll control block
package scp_pkg;
  typedef struct packed {
    logic clk_cpu_en;
    logic clk_io_en;
    logic clk_adc_en;
    logic clk_flash_en;
  } scp_clk_en_t;
  typedef enum logic [1:0] {
    SCP_PLL_OFF,
    SCP_PLL_LOCKING,
    SCP_PLL_LOCKED
  } scp_pll_state_t;
endpackage

// ### scp_clock_ctrl.sv
// system clock prescaler and usb pll control with an apb slave
//
// The APB register port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`include "scp_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: divide cpu, flash, io, adc clocks by 2^select; codes 0..8 valid, others reserved
// RULE2: divider switches without glitches on clock outputs
// RULE3: no intermediate period faster than both old and new settings
// RULE4: new rate active within one old plus one to two new periods
// RULE5: software writes change-enable alone, then select within four cycles
// RULE6: software keeps interrupts off through the two-write sequence
// RULE7: select written only while change-enable is set
// RULE8: change-enable updates only when all other bits are written zero
// RULE9: change-enable self-clears after four cycles or when select is written
// RULE10: rewriting change-enable inside window neither restarts timeout nor clears it
// RULE11: reset select is 0000, or 0011 when divide-by-eight fuse programmed
// RULE12: any select code accepted regardless of fuse; fuse sets reset only
// RULE13: usb pll multiplies its 2 MHz reference by 24
// RULE14: pll prescaler: 011 divides by 4, 101 or 110 by 8 per variant
// RULE15: pll reference comes from crystal or external clock, never rc
// RULE16: setting pll enable starts the pll
// RULE17: lock bit sets once pll locked, about 100 ms after enable
// RULE18: lock clears when enable and prescaler are both cleared
// RULE19: upper three bits of pll register read zero
// RULE20: clock output pin carries the divided system clock; at factor 1 (select 0000) the code holds the pin high instead
// RULE21: lock bit is read-only
module scp_clock_ctrl
  import scp_pkg::*;
#(
  parameter int LOCK_CYCLES = `SCP_LOCK_CYCLES,
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic divide_by_eight_fuse,
  input wire logic clock_out_fuse,
  input wire logic pll_ref_xtal_sel,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output scp_clk_en_t sys_clk_en,
  output logic clock_output_pin,
  output logic pll_run,
  output logic [3:0] pll_ref_div,
  output logic pll_lock_status
);
  // sys_clk_en is a one-cycle enable tick per divided period; a clock-enable
  // scheme is glitch-free by construction, unlike a muxed ripple counter

  function automatic logic [8:0] div_factor(input logic [3:0] sel);
    div_factor = 9'h001 << sel;
  endfunction

  logic [3:0] divider_select_r;
  logic divider_change_enable_r;
  logic [2:0] ce_cnt_r;
  logic [7:0] div_cnt_r;
  logic [3:0] active_sel_r;
  logic pending_r;
  logic [2:0] pll_input_prescaler_r;
  logic pll_enable_r;
  logic [26:0] lock_cnt_r;
  scp_pll_state_t pll_state_r;
  logic fuse_done_r;
  logic tick_r;

  wire acc = psel & penable & clk_en;
  wire wr = acc & pwrite;
  wire hit_div = paddr == `SCP_OFF_DIV;
  wire hit_pll = paddr == `SCP_OFF_PLL;
  wire wr_div = wr & hit_div;
  wire wr_pll = wr & hit_pll;
  wire ce_only = pwdata[7:0] == 8'h80; // RULE8
  wire sel_wr = wr_div & ~pwdata[`SCP_DIV_CE_BIT] & divider_change_enable_r; // RULE7 RULE5
  // reserved select codes are kept out so the divider stays in range
  wire sel_ok = pwdata[3:0] <= `SCP_DIV_SEL_MAX; // RULE1 RULE12
  wire [7:0] div_rd = {divider_change_enable_r, 3'h0, divider_select_r};
  wire [7:0] pll_rd = {3'h0, pll_input_prescaler_r, pll_enable_r, pll_lock_status}; // RULE19 RULE21
  wire [7:0] last_cnt = 8'(div_factor(active_sel_r) - 9'h001);
  wire period_end = div_cnt_r >= last_cnt;
  wire pre_ok = pll_input_prescaler_r == `SCP_PRE_DIV4 ||
    (LARGE_VARIANT && pll_input_prescaler_r == `SCP_PRE_DIV8_LG) ||
    (!LARGE_VARIANT && pll_input_prescaler_r == `SCP_PRE_DIV8_SM); // RULE14
  wire [3:0] ref_div = (pll_input_prescaler_r == `SCP_PRE_DIV4) ? 4'h4 : 4'h8;
  // reference only from crystal or external clock
  wire pll_go = pll_enable_r & pre_ok & pll_ref_xtal_sel; // RULE15 RULE16

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: zero wait states, unmapped addresses answer pslverr
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~(paddr == `SCP_OFF_DIV || paddr == `SCP_OFF_PLL);
      prdata <= (psel & ~penable & ~pwrite) ?
        (paddr == `SCP_OFF_DIV ? {24'h00_0000, div_rd} :
         paddr == `SCP_OFF_PLL ? {24'h00_0000, pll_rd} : 32'h0000_0000) : 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protected divider write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      divider_change_enable_r <= 1'b0;
      ce_cnt_r <= 3'h0;
    end else if (clk_en) begin
      if (sel_wr) begin
        divider_change_enable_r <= 1'b0; // RULE9
      end else if (wr_div & ce_only & ~divider_change_enable_r) begin
        divider_change_enable_r <= 1'b1; // RULE8 RULE10
        ce_cnt_r <= `SCP_CE_WINDOW;
      end else if (divider_change_enable_r) begin
        ce_cnt_r <= ce_cnt_r - 3'h1;
        if (ce_cnt_r == 3'h1) begin
          divider_change_enable_r <= 1'b0; // RULE9
        end
      end
    end
  end

  // fuse is caught one edge after reset release, never in the async branch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fuse_done_r <= 1'b0;
      divider_select_r <= `SCP_DIV_RST_PLAIN;
    end else if (clk_en && !fuse_done_r) begin
      fuse_done_r <= 1'b1;
      divider_select_r <= divide_by_eight_fuse ? `SCP_DIV_RST_FUSED : `SCP_DIV_RST_PLAIN; // RULE11
    end else if (clk_en && sel_wr && sel_ok) begin
      divider_select_r <= pwdata[3:0]; // RULE7 RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divider: new setting is adopted only at the end of the running period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_r <= 8'h00;
      active_sel_r <= `SCP_DIV_RST_PLAIN;
      pending_r <= 1'b0;
      tick_r <= 1'b0;
    end else if (clk_en) begin
      pending_r <= active_sel_r != divider_select_r;
      tick_r <= period_end; // RULE1
      if (period_end) begin
        div_cnt_r <= 8'h00;
        active_sel_r <= divider_select_r; // RULE2 RULE3 RULE4
      end else begin
        div_cnt_r <= div_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_clk_en <= '0;
      clock_output_pin <= 1'b0;
    end else if (clk_en) begin
      sys_clk_en <= {4{period_end}};
      // high for the first half of each divided period; at factor 1 held high
      clock_output_pin <= clock_out_fuse &
        (active_sel_r == 4'h0 ? 1'b1 : div_cnt_r < 8'(div_factor(active_sel_r) >> 1)); // RULE20
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pll control and lock timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_input_prescaler_r <= 3'h0;
      pll_enable_r <= 1'b0;
    end else if (clk_en && wr_pll) begin
      pll_input_prescaler_r <= pwdata[4:2];
      pll_enable_r <= pwdata[`SCP_PLL_EN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pll_state_r <= SCP_PLL_OFF;
      lock_cnt_r <= 27'h000_0000;
      pll_lock_status <= 1'b0;
      pll_run <= 1'b0;
      pll_ref_div <= 4'h0;
    end else if (clk_en) begin
      pll_run <= pll_go; // RULE16
      pll_ref_div <= pll_go ? ref_div : 4'h0; // RULE13 RULE14
      case (pll_state_r)
        SCP_PLL_OFF: begin
          if (pll_go) begin
            pll_state_r <= SCP_PLL_LOCKING;
            lock_cnt_r <= 27'h000_0000;
          end
        end
        SCP_PLL_LOCKING: begin
          if (!pll_go) begin
            pll_state_r <= SCP_PLL_OFF;
          end else if (lock_cnt_r >= 27'(LOCK_CYCLES - 1)) begin
            pll_state_r <= SCP_PLL_LOCKED;
            pll_lock_status <= 1'b1; // RULE17
          end else begin
            lock_cnt_r <= lock_cnt_r + 27'h000_0001;
          end
        end
        SCP_PLL_LOCKED: begin
          if (!pll_enable_r && pll_input_prescaler_r == 3'h0) begin
            pll_state_r <= SCP_PLL_OFF;
            pll_lock_status <= 1'b0; // RULE18
          end
        end
        default: pll_state_r <= SCP_PLL_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // assertions
  AST_CE_ONLY_CLEAN: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
    (clk_en && wr_div && !ce_only && !divider_change_enable_r) |=> !divider_change_enable_r)
    else $error("change enable set by a dirty write");
  AST_CE_TIMEOUT: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
    $rose(divider_change_enable_r) && clk_en |-> ##[1:4] !divider_change_enable_r || !clk_en)
    else $error("change enable outlived its window");
  AST_NO_SEL_OUTSIDE: assert property (@(posedge pclk) disable iff (!presetn || !fuse_done_r) // RULE7
    (clk_en && wr_div && !divider_change_enable_r) |=> $stable(divider_select_r))
    else $error("select changed without change enable");
  AST_CE_NO_RESTART: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
    (clk_en && divider_change_enable_r && wr_div && ce_only) |=> divider_change_enable_r == (ce_cnt_r != 3'h0))
    else $error("rewrite cleared change enable early");
  AST_FUSE_RESET: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
    $rose(fuse_done_r) |-> divider_select_r == (divide_by_eight_fuse ? 4'h3 : 4'h0))
    else $error("wrong reset select");
  AST_SWITCH_AT_END: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
    (clk_en && !period_end) |=> $stable(active_sel_r))
    else $error("divider switched mid period");
  AST_SEL_RANGE: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
    divider_select_r <= 4'h8)
    else $error("reserved select code stored");
  AST_LOCK_NEEDS_RUN: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
    $rose(pll_lock_status) |-> $past(pll_state_r) == SCP_PLL_LOCKING && pll_run)
    else $error("lock without a locking pll");
  AST_LOCK_CLEAR: assert property (@(posedge pclk) disable iff (!presetn) // RULE18
    (clk_en && pll_lock_status && !pll_enable_r && pll_input_prescaler_r == 3'h0) |=> !pll_lock_status)
    else $error("lock not cleared");
  AST_RES_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
    pll_rd[7:5] == 3'h0)
    else $error("reserved pll bits not zero");
  COV_DIV_CHANGE: cover property (@(posedge pclk) disable iff (!presetn) sel_wr && sel_ok);
  COV_CE_TIMEOUT: cover property (@(posedge pclk) disable iff (!presetn) $fell(divider_change_enable_r) && !sel_wr);
  COV_PLL_LOCK: cover property (@(posedge pclk) disable iff (!presetn) $rose(pll_lock_status));
  COV_SWITCH: cover property (@(posedge pclk) disable iff (!presetn) pending_r && period_end);
endmodule

// ### scp_clock_ctrl_tb.sv
// self-checking testbench for the clock prescaler and pll control block
`timescale 1ns/100ps
`include "scp_map.svh"
module scp_clock_ctrl_tb
  import scp_pkg::*;
;
  localparam int LOCK = 20;
  logic pclk, presetn, clk_en, fuse8, cofuse, xsel, psel, penable, pwrite, pready, pslverr, err;
  logic pll_run, pll_lock_status, clock_output_pin;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pll_ref_div, sel;
  scp_clk_en_t sys_clk_en;
  int fails = 0;
  int n_tests = 0;
  int cnt;
  scp_clock_ctrl #(.LOCK_CYCLES(LOCK), .LARGE_VARIANT(1'b1)) dut_u (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .divide_by_eight_fuse(fuse8), .clock_out_fuse(cofuse), .pll_ref_xtal_sel(xsel),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sys_clk_en(sys_clk_en), .clock_output_pin(clock_output_pin),
    .pll_run(pll_run), .pll_ref_div(pll_ref_div), .pll_lock_status(pll_lock_status));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic hang();
    fails++;
    $display("BAD t=%0t wait ran out", $time);
    finish_test();
  endtask
  // one apb transfer; rd and err are taken at the edge where pready is seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) hang();
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst(input logic f);
    presetn <= 1'b0;
    fuse8 <= f;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
  endtask
  // edges from one enable pulse to the next
  task automatic pulse_gap(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (sys_clk_en.clk_cpu_en !== 1'b1 && n < 600);
    if (n >= 600) hang();
  endtask
  function automatic logic [3:0] pre_div(input logic [2:0] c);
    return (c == 3'h3) ? 4'h4 : ((c == 3'h5) ? 4'h8 : 4'h0);
  endfunction
  // old period may still be running, so only the third gap counts
  task automatic measure(input logic [3:0] s);
    repeat (3) pulse_gap(cnt);
    chk(cnt, 32'h0000_0001 << s);
    chk(sys_clk_en, 4'hf);
  endtask
  task automatic set_div(input logic [3:0] s);
    // bench keeps the two writes back to back, nothing in between
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0080);
    apb(1'b1, `SCP_OFF_DIV, {28'h000_0000, s});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0; clk_en = 1'b1; fuse8 = 1'b0; cofuse = 1'b1; xsel = 1'b1;
    psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000;
    void'($urandom(32'hf615));
    rst(1'b0);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    measure(4'h0);
    rst(1'b1);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    measure(4'h3);
    apb(1'b0, 12'h008, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, err}, 32'h0000_0001);
    $display("test reset and decode done");
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0005);
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0081);
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0006);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    // second enable write must not stretch the window past the select write
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0080);
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0080);
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0001);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, `SCP_OFF_DIV, 32'h0000_0080);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0083);
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    $display("test protected write done");
    for (int k = 0; k < 6; k++) begin
      sel = (k == 0) ? 4'h8 : ((k == 1) ? 4'h0 : 4'($urandom % 9));
      set_div(sel);
      apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
      chk(rd, {28'h000_0000, sel});
      measure(sel);
    end
    set_div(4'($urandom % 7 + 9));
    apb(1'b0, `SCP_OFF_DIV, 32'h0000_0000);
    chk(rd, {28'h000_0000, sel});
    set_div(4'h1);
    // let the old period run out before counting the output pin
    measure(4'h1);
    cnt = 0;
    repeat (16) begin
      @(posedge pclk);
      cnt += int'(clock_output_pin);
    end
    chk(cnt, 8);
    $display("test divider done");
    apb(1'b1, `SCP_OFF_PLL, 32'h0000_00e0);
    apb(1'b0, `SCP_OFF_PLL, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `SCP_OFF_PLL, {27'h000_0000, 3'(c), 2'b11});
      repeat (2) @(posedge pclk);
      chk(pll_run, pre_div(3'(c)) != 4'h0);
      chk(pll_ref_div, pre_div(3'(c)));
      apb(1'b1, `SCP_OFF_PLL, 32'h0000_0000);
    end
    apb(1'b1, `SCP_OFF_PLL, 32'h0000_000f);
    apb(1'b0, `SCP_OFF_PLL, 32'h0000_0000);
    chk(rd, 32'h0000_000e);
    cnt = 3;
    while (pll_lock_status !== 1'b1 && cnt < 200) begin
      @(posedge pclk);
      cnt++;
    end
    chk(cnt >= LOCK && cnt <= LOCK + 4, 1'b1);
    apb(1'b1, `SCP_OFF_PLL, 32'h0000_0000);
    repeat (2) @(posedge pclk);
    chk({pll_lock_status, pll_run}, 2'b00);
    xsel <= 1'b0;
    apb(1'b1, `SCP_OFF_PLL, 32'h0000_000e);
    repeat (2) @(posedge pclk);
    chk(pll_run, 1'b0);
    $display("test pll done");
    finish_test();
  end
  initial begin
    repeat (100000) @(posedge pclk);
    hang();
  end
endmodule
